// ### core/spn_status_nvm_map.vh
// register offsets, field positions, reset values and codes for the status pin and memory commit block
// Overview of operation
// - Upper status-pin selector is bits 7-4, resets 5h, codes 0h-Eh.
// - Lower status-pin selector is bits 3-0, resets 3h, same codes.
// - Bit 15 skips checksum on soft-reset and bit-13 loads, never on the load after reset_n.
// - Writing one to bit 14 recomputes checksum; result valid when busy clears.
// - Bit 13 loads memory contents into registers, then clears itself.
// - A memory-to-register load also runs automatically after every reset.
// - Registers are not readable while a memory-to-register load runs.
// - A load starts only once the always-on clock is active.
// - Bit 12 copies registers into the memory array, clears when done.
// - Bit 11 chooses memory page 0 or 1 for commit operations.
// - Initial power-up load uses the page-select pin, not the register bit.
// - Bits 10 and 9 include channels 4 and 3 integer dividers in stepping.
// - Masked-in integer and fractional dividers step by their own step sizes.
// - A set channel-3 integer mask bit includes that divider in stepping.
// - Writing one to the register increment bit steps dividers up, self-clearing.
// - Step-source bit picks pin (0) or register (1) step requests.
`ifndef SPN_STATUS_NVM_MAP_VH
`define SPN_STATUS_NVM_MAP_VH

`define SPN_ADDR_PIN_SEL     8'h02
`define SPN_ADDR_NVM_CTL     8'h03

`define SPN_RST_PIN_SEL      16'h0053
`define SPN_RST_NVM_CTL      16'h0000

`define SPN_UPPER_SEL_MSB    7
`define SPN_UPPER_SEL_LSB    4
`define SPN_LOWER_SEL_MSB    3
`define SPN_LOWER_SEL_LSB    0
`define SPN_IOD_SIZE_BIT     14

`define SPN_CRC_OFF_BIT      15
`define SPN_CRC_UPD_BIT      14
`define SPN_LOAD_BIT         13
`define SPN_STORE_BIT        12
`define SPN_PAGE_BIT         11
`define SPN_IOD_MASK_MSB     10
`define SPN_IOD_MASK_LSB     7
`define SPN_FOD_MASK_MSB     6
`define SPN_FOD_MASK_LSB     3
`define SPN_DEC_BIT          2
`define SPN_INC_BIT          1
`define SPN_REG_MODE_BIT     0

// bits of the control word that a write stores directly
`define SPN_CTL_PLAIN_MASK   16'h8FF9

`define SPN_BUSY_STATUS_CODE 5

`endif

// ### core/spn_status_nvm.v
// status pin selection, memory commit control and divider step masks
`timescale 1ns/100ps
`include "spn_status_nvm_map.vh"

module spn_status_nvm (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        soft_reset,
  // register access port from the serial front end
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rd_ack,
  // pins and internal status
  input  wire        page_select_pin,
  input  wire        aon_clock_active,
  input  wire        frequency_step_up,
  input  wire        frequency_step_down,
  input  wire [14:0] status_in,
  output reg         upper_general_pin,
  output reg         lower_general_pin,
  // memory engine
  output reg         nvm_load_req,
  output reg         nvm_store_req,
  output reg         nvm_crc_req,
  output reg         nvm_page,
  output reg         nvm_crc_skip,
  input  wire        nvm_done,
  input  wire        nvm_load_we,
  input  wire [7:0]  nvm_load_addr,
  input  wire [15:0] nvm_load_data,
  output wire        nvm_busy,
  output wire        load_busy,
  output reg  [15:0] pin_sel_image,
  output reg  [15:0] nvm_ctl_image,
  // divider stepping
  output reg  [3:0]  iod_step_up,
  output reg  [3:0]  iod_step_down,
  output reg  [3:0]  fod_step_up,
  output reg  [3:0]  fod_step_down,
  output reg         iod_size_sel
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_LOAD  = 3'h2;
  localparam [2:0] ST_STORE = 3'h3;
  localparam [2:0] ST_CRC   = 3'h4;

  reg        rst_meta_reg;
  reg        rst_sync_reg;
  wire       rst_n;

  // reset release through two flops
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // two-flop synchronisers for pins and foreign status
  reg [18:0] in_meta_reg;
  reg [18:0] in_sync_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_reg <= 19'h00000;
      in_sync_reg <= 19'h00000;
    end else begin
      in_meta_reg <= {page_select_pin, aon_clock_active, frequency_step_up, frequency_step_down, status_in};
      in_sync_reg <= in_meta_reg;
    end
  end
  wire        page_pin_s = in_sync_reg[18];
  wire        aon_s      = in_sync_reg[17];
  wire        up_pin_s   = in_sync_reg[16];
  wire        down_pin_s = in_sync_reg[15];
  wire [14:0] status_s   = in_sync_reg[14:0];

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [15:0] sel_reg;
  reg [15:0] ctl_reg;
  reg        boot_reg;
  reg        por_reg;
  reg        up_prev_reg;
  reg        down_prev_reg;

  assign nvm_busy  = (state_reg != ST_IDLE);
  assign load_busy = (state_reg == ST_LOAD) || (state_reg == ST_WAIT);

  wire load_wanted = boot_reg || ctl_reg[`SPN_LOAD_BIT];
  // host writes are dropped during a load so the loaded image wins
  wire wr_sel = reg_wr && !load_busy && (reg_addr == `SPN_ADDR_PIN_SEL);
  wire wr_ctl = reg_wr && !load_busy && (reg_addr == `SPN_ADDR_NVM_CTL);
  wire ld_sel = nvm_load_we && (state_reg == ST_LOAD) && (nvm_load_addr == `SPN_ADDR_PIN_SEL);
  wire ld_ctl = nvm_load_we && (state_reg == ST_LOAD) && (nvm_load_addr == `SPN_ADDR_NVM_CTL);

  // sequencer; a load waits for the always-on clock
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (load_wanted)
          state_next = ST_WAIT;
        else if (ctl_reg[`SPN_STORE_BIT])
          state_next = ST_STORE;
        else if (ctl_reg[`SPN_CRC_UPD_BIT])
          state_next = ST_CRC;
      end
      ST_WAIT: begin
        if (aon_s)
          state_next = ST_LOAD;
      end
      ST_LOAD, ST_STORE, ST_CRC: begin
        if (nvm_done)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire enter_load  = (state_reg == ST_WAIT) && aon_s;
  wire enter_store = (state_reg == ST_IDLE) && !load_wanted && ctl_reg[`SPN_STORE_BIT];
  wire enter_crc   = (state_reg == ST_IDLE) && !load_wanted && !ctl_reg[`SPN_STORE_BIT]
                     && ctl_reg[`SPN_CRC_UPD_BIT];
  wire done_load   = (state_reg == ST_LOAD) && nvm_done;
  wire done_store  = (state_reg == ST_STORE) && nvm_done;
  wire done_crc    = (state_reg == ST_CRC) && nvm_done;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else if (soft_reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // engine requests: page and checksum policy latched at start
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_load_req  <= 1'b0;
      nvm_store_req <= 1'b0;
      nvm_crc_req   <= 1'b0;
      nvm_page      <= 1'b0;
      nvm_crc_skip  <= 1'b0;
      boot_reg      <= 1'b1;
      por_reg       <= 1'b1;
    end else begin
      nvm_load_req  <= enter_load && !soft_reset;
      nvm_store_req <= enter_store && !soft_reset;
      nvm_crc_req   <= enter_crc && !soft_reset;
      if (enter_load || enter_store) begin
        // boot load follows the pin, later commits the register bit
        nvm_page <= boot_reg ? page_pin_s : ctl_reg[`SPN_PAGE_BIT];
        nvm_crc_skip <= ctl_reg[`SPN_CRC_OFF_BIT] && !(boot_reg && por_reg);
      end
      if (soft_reset) begin
        boot_reg <= 1'b1;
        por_reg  <= 1'b0;
      end else if (done_load) begin
        boot_reg <= 1'b0;
        por_reg  <= 1'b0;
      end
    end
  end

  // selector register
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      sel_reg <= `SPN_RST_PIN_SEL;
    else if (soft_reset)
      sel_reg <= `SPN_RST_PIN_SEL;
    else if (ld_sel)
      sel_reg <= nvm_load_data;
    else if (wr_sel)
      sel_reg <= reg_wdata;
  end

  // control register; a host write setting a store or checksum request wins over its hardware clear
  reg [15:0] ctl_next;
  always @* begin
    ctl_next = ctl_reg;
    ctl_next[`SPN_INC_BIT] = 1'b0;
    ctl_next[`SPN_DEC_BIT] = 1'b0;
    if (done_load)
      ctl_next[`SPN_LOAD_BIT] = 1'b0;
    if (done_store)
      ctl_next[`SPN_STORE_BIT] = 1'b0;
    if (done_crc)
      ctl_next[`SPN_CRC_UPD_BIT] = 1'b0;
    if (ld_ctl)
      ctl_next = (nvm_load_data & `SPN_CTL_PLAIN_MASK) | (ctl_next & ~`SPN_CTL_PLAIN_MASK);
    if (wr_ctl) begin
      ctl_next = (reg_wdata & `SPN_CTL_PLAIN_MASK) | (ctl_next & ~`SPN_CTL_PLAIN_MASK);
      if (reg_wdata[`SPN_CRC_UPD_BIT])
        ctl_next[`SPN_CRC_UPD_BIT] = 1'b1;
      if (reg_wdata[`SPN_LOAD_BIT])
        ctl_next[`SPN_LOAD_BIT] = 1'b1;
      if (reg_wdata[`SPN_STORE_BIT])
        ctl_next[`SPN_STORE_BIT] = 1'b1;
      ctl_next[`SPN_INC_BIT] = reg_wdata[`SPN_INC_BIT];
      ctl_next[`SPN_DEC_BIT] = reg_wdata[`SPN_DEC_BIT];
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      ctl_reg <= `SPN_RST_NVM_CTL;
    else if (soft_reset)
      // checksum bypass survives so the following load can honour it
      ctl_reg <= `SPN_RST_NVM_CTL | (ctl_reg & (16'h0001 << `SPN_CRC_OFF_BIT));
    else
      ctl_reg <= ctl_next;
  end

  // register reads are withheld while a load rewrites them
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rd_ack <= 1'b0;
    end else begin
      // unmapped addresses read zero but are still acknowledged
      reg_rd_ack <= reg_rd && !load_busy;
      if (reg_rd && !load_busy) begin
        case (reg_addr)
          `SPN_ADDR_PIN_SEL: reg_rdata <= sel_reg;
          `SPN_ADDR_NVM_CTL: reg_rdata <= ctl_reg;
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // status pin routing; own busy replaces the foreign input at its code
  wire [15:0] status_vec;
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1) begin : g_status
      if (gi == `SPN_BUSY_STATUS_CODE) begin : g_own
        assign status_vec[gi] = nvm_busy;
      end else begin : g_ext
        assign status_vec[gi] = status_s[gi];
      end
    end
  endgenerate
  // code Fh has no source and reads low
  assign status_vec[15] = 1'b0;
  wire [3:0]  upper_code = sel_reg[`SPN_UPPER_SEL_MSB:`SPN_UPPER_SEL_LSB];
  wire [3:0]  lower_code = sel_reg[`SPN_LOWER_SEL_MSB:`SPN_LOWER_SEL_LSB];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_general_pin <= 1'b0;
      lower_general_pin <= 1'b0;
      pin_sel_image     <= `SPN_RST_PIN_SEL;
      nvm_ctl_image     <= `SPN_RST_NVM_CTL;
    end else begin
      upper_general_pin <= status_vec[upper_code];
      lower_general_pin <= status_vec[lower_code];
      pin_sel_image     <= sel_reg;
      nvm_ctl_image     <= ctl_reg;
    end
  end

  // step requests: pin edges or register pulses
  // pin edges are taken after the synchroniser, so a step lands three cycles late
  wire reg_mode = ctl_reg[`SPN_REG_MODE_BIT];
  wire up_req   = reg_mode ? ctl_reg[`SPN_INC_BIT] : (up_pin_s && !up_prev_reg);
  wire down_req = reg_mode ? ctl_reg[`SPN_DEC_BIT] : (down_pin_s && !down_prev_reg);
  wire [3:0] iod_mask = ctl_reg[`SPN_IOD_MASK_MSB:`SPN_IOD_MASK_LSB];
  wire [3:0] fod_mask = ctl_reg[`SPN_FOD_MASK_MSB:`SPN_FOD_MASK_LSB];

  // outputs are ordered ch4..ch1; dividers apply their own step sizes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_prev_reg   <= 1'b0;
      down_prev_reg <= 1'b0;
      iod_step_up   <= 4'h0;
      iod_step_down <= 4'h0;
      fod_step_up   <= 4'h0;
      fod_step_down <= 4'h0;
      iod_size_sel  <= 1'b0;
    end else begin
      up_prev_reg   <= up_pin_s;
      down_prev_reg <= down_pin_s;
      iod_step_up   <= iod_mask & {4{up_req}};
      iod_step_down <= iod_mask & {4{down_req}};
      fod_step_up   <= fod_mask & {4{up_req}};
      fod_step_down <= fod_mask & {4{down_req}};
      iod_size_sel  <= sel_reg[`SPN_IOD_SIZE_BIT];
    end
  end

endmodule // spn_status_nvm

// ### bench/spn_nvm_engine.sv
// memory engine model answering load, store and checksum requests
`timescale 1ns/100ps

module spn_nvm_engine (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  lat,
  input  wire logic        nvm_load_req,
  input  wire logic        nvm_store_req,
  input  wire logic        nvm_crc_req,
  output logic             nvm_done,
  output logic             nvm_load_we,
  output logic      [7:0]  nvm_load_addr,
  output logic      [15:0] nvm_load_data
);
  logic [7:0] cnt_reg;
  logic       ld_reg;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
      ld_reg  <= 1'b0;
    end else if (nvm_load_req || nvm_store_req || nvm_crc_req) begin
      cnt_reg <= lat;
      ld_reg  <= nvm_load_req;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  assign nvm_done      = (cnt_reg == 8'h01);
  // stored image rewrites the selector with its reset word
  assign nvm_load_we   = ld_reg && (cnt_reg == 8'h03);
  // idle bus wanders so stale data is never mistaken for a write
  assign nvm_load_addr = (cnt_reg == 8'h03) ? 8'h02 : cnt_reg;
  assign nvm_load_data = (cnt_reg == 8'h03) ? 16'h0053 : {8'hA5, cnt_reg};
endmodule // spn_nvm_engine

// ### bench/spn_status_nvm_chk.sv
// concurrent checks on the status pin and memory commit block
`timescale 1ns/100ps

module spn_status_nvm_chk (
  // clock, reset and register port
  input wire logic        sys_clk, reset_n, reg_wr, reg_rd, reg_rd_ack,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata, pin_sel_image, nvm_ctl_image,
  // engine and pins
  input wire logic        aon_clock_active, load_busy, nvm_busy, nvm_load_req, nvm_store_req,
  input wire logic        upper_general_pin, lower_general_pin,
  input wire logic [3:0]  iod_step_up, iod_step_down, fod_step_up, fod_step_down
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ctl_wr;
    reg_wr && !load_busy && !nvm_busy && reg_addr == 8'h03;
  endsequence
  sequence s_store_go;
    ##[2:4] nvm_store_req;
  endsequence

  a_read_answered: assert property (reg_rd && !load_busy |=> reg_rd_ack)
    else $error("read not answered");
  a_read_refused: assert property (reg_rd && load_busy |=> !reg_rd_ack)
    else $error("read answered during load");
  a_load_clock_on: assert property (nvm_load_req |-> $past(aon_clock_active, 3))
    else $error("load without clock");
  a_load_shows_busy: assert property (nvm_load_req |-> load_busy)
    else $error("load request while not busy");
  a_store_starts: assert property (s_ctl_wr and reg_wdata[12] |-> s_store_go)
    else $error("store not started");
  a_upper_off_low: assert property ((pin_sel_image[7:4] == 4'hF) [*2] |-> !upper_general_pin)
    else $error("upper pin not low");
  a_lower_off_low: assert property ((pin_sel_image[3:0] == 4'hF) [*2] |-> !lower_general_pin)
    else $error("lower pin not low");
  a_reg_inc_iod: assert property (s_ctl_wr and reg_wdata[1:0] == 2'b11 |-> ##2 iod_step_up == nvm_ctl_image[10:7])
    else $error("integer step up mask");
  a_reg_inc_fod: assert property (s_ctl_wr and reg_wdata[1:0] == 2'b11 |-> ##2 fod_step_up == nvm_ctl_image[6:3])
    else $error("fractional step up mask");
  a_reg_dec_iod: assert property (s_ctl_wr and reg_wdata[2] && reg_wdata[0] |-> ##2 iod_step_down == nvm_ctl_image[10:7])
    else $error("integer step down mask");
  a_reg_dec_fod: assert property (s_ctl_wr and reg_wdata[2] && reg_wdata[0] |-> ##2 fod_step_down == nvm_ctl_image[6:3])
    else $error("fractional step down mask");
endmodule // spn_status_nvm_chk

bind spn_status_nvm spn_status_nvm_chk u_chk (.*);

// ### bench/spn_status_nvm_tb.sv
// self-checking bench for the status pin and memory commit block
`timescale 1ns/100ps

module spn_status_nvm_tb;
  logic        sys_clk = 0, reset_n = 0, soft_reset = 0, reg_wr = 0, reg_rd = 0, page_select_pin = 1;
  logic        aon_clock_active = 0, frequency_step_up = 0, frequency_step_down = 0, reg_rd_ack, ack;
  logic        upper_general_pin, lower_general_pin, nvm_load_req, nvm_store_req, nvm_crc_req, nvm_page;
  logic        nvm_crc_skip, nvm_done, nvm_load_we, nvm_busy, load_busy, iod_size_sel;
  logic [7:0]  reg_addr = 8'h00, lat = 8'h06, nvm_load_addr;
  logic [14:0] status_in = 15'h0000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, pin_sel_image, nvm_ctl_image, nvm_load_data, d;
  logic [3:0]  iod_step_up, iod_step_down, fod_step_up, fod_step_down;
  int          miscompares = 0, check_count = 0;

  spn_status_nvm dut (.*);
  spn_nvm_engine u_eng (.*);

  always #20 sys_clk = ~sys_clk;

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end

  task automatic chk(input logic [15:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge sys_clk);
    ack = reg_rd_ack;
    d = reg_rdata;
    reg_rd = 0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string m);
    rd(a);
    chk(16'(ack), 16'h0001, m);
    chk(d, e, m);
  endtask

  task automatic wait_val(ref logic s, input logic v, input string m);
    int n = 0;
    while (s !== v && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(s), 16'(v), m);
  endtask

  task t_boot;
    repeat (8) @(negedge sys_clk);
    chk(16'(load_busy), 16'h0001, "load waits for clock");
    aon_clock_active = 1;
    wait_val(nvm_load_req, 1, "boot load");
    chk(16'(nvm_page), 16'h0001, "boot page from pin");
    chk(16'(nvm_crc_skip), 16'h0000, "power-on crc");
    wait_val(load_busy, 0, "boot end");
  endtask

  task t_pins;
    rc(8'h02, 16'h0053, "selector reset");
    rc(8'h03, 16'h0000, "control reset");
    rc(8'h40, 16'h0000, "unmapped read");
    for (int c = 0; c < 16; c++) begin
      status_in = c[0] ? 15'(1 << c) : ~15'(1 << c);
      wr(8'h02, {8'h00, 4'(c), 4'(15 - c)});
      repeat (5) @(negedge sys_clk);
      chk(16'(upper_general_pin), 16'(c[0] && c != 5 && c != 15), "upper pin");
      chk(16'(lower_general_pin), 16'(!c[0] && c != 10 && c != 0), "lower pin");
    end
    wr(8'h02, 16'h4053);
    repeat (3) @(negedge sys_clk);
    chk(16'(iod_size_sel), 16'h0001, "integer step size select");
    rc(8'h02, 16'h4053, "selector size bit");
  endtask

  task t_store;
    for (int p = 0; p < 2; p++) begin
      wr(8'h03, {4'h1, 1'(p), 11'h000});
      wait_val(nvm_store_req, 1, "store request");
      chk(16'(nvm_page), 16'(p), "store page");
      wait_val(nvm_busy, 0, "store end");
      rc(8'h03, {4'h0, 1'(p), 11'h000}, "store cleared");
    end
    wr(8'h03, 16'h4000);
    wait_val(nvm_crc_req, 1, "crc request");
    wait_val(nvm_busy, 0, "crc end");
    rc(8'h03, 16'h0000, "crc cleared");
  endtask

  task t_load;
    lat = 8'h28;
    wr(8'h03, 16'h2000);
    wait_val(load_busy, 1, "load start");
    rd(8'h03);
    chk(16'(ack), 16'h0000, "read during load");
    wr(8'h02, 16'h00FF);
    wait_val(load_busy, 0, "load end");
    lat = 8'h06;
    rc(8'h03, 16'h0000, "load cleared");
    rc(8'h02, 16'h0053, "loaded selector");
  endtask

  task t_steps;
    int n;
    wr(8'h03, 16'h0649);
    wr(8'h03, 16'h064B);
    @(negedge sys_clk);
    chk(16'(iod_step_up), 16'h000C, "reg step up iod");
    chk(16'(fod_step_up), 16'h0009, "reg step up fod");
    wr(8'h03, 16'h064D);
    @(negedge sys_clk);
    chk(16'(iod_step_down), 16'h000C, "reg step down");
    rc(8'h03, 16'h0649, "step bits cleared");
    wr(8'h03, 16'h0648);
    frequency_step_up = 1;
    n = 0;
    while (iod_step_up === 4'h0 && n < 12) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(iod_step_up), 16'h000C, "pin step up");
    frequency_step_up = 0;
    frequency_step_down = 1;
    n = 0;
    while (fod_step_down === 4'h0 && n < 12) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(fod_step_down), 16'h0009, "pin step down fod");
    chk(16'(iod_step_down), 16'h000C, "pin step down iod");
    frequency_step_down = 0;
  endtask

  task t_soft;
    wr(8'h03, 16'h8000);
    @(negedge sys_clk);
    soft_reset = 1;
    @(negedge sys_clk);
    soft_reset = 0;
    wait_val(nvm_load_req, 1, "reload after soft reset");
    chk(16'(nvm_crc_skip), 16'h0001, "crc bypass");
    chk(16'(nvm_page), 16'h0001, "reload page from pin");
    wait_val(load_busy, 0, "reload end");
    rc(8'h03, 16'h8000, "bypass kept");
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1;
    t_boot();
    t_pins();
    t_store();
    t_load();
    t_steps();
    t_soft();
    report_and_stop();
  end
endmodule // spn_status_nvm_tb
